/* File: rtl/shift_carry_unit.sv */
`timescale 1ns/1ns
// Function
// - Zero length passes operand through and keeps carry unchanged.
// - Flag-setting shift with non-zero length loads carry from shifter.
// - Arithmetic right fills top bits with operand bit 31.
// - Arithmetic right below 32 gives carry from bit n-1.
// - Arithmetic right of 32 or more: all bits and carry are bit 31.
// - Logical right moves bits down and zero-fills the top.
// - Logical right 1 to 32 gives carry from bit n-1.
// - Logical shifts of 32 or more give zero; carry zero from 33.
// - Logical left moves bits up and zero-fills the bottom.
// - Left shift and flag-setting move/logic operands carry out bit 32-n.
// - Rotate right wraps low bits into the top.
// - Rotate right 1 to 31 gives carry from bit n-1.
// - Rotate by exactly 32 returns operand, carry from bit 31.
// - Rotate beyond 32 acts as rotate by length minus 32.
// - Bit 0 of branch or pop target selects instruction set; 1 required.
// - Link register value written by linked branches has bit 0 forced.
// - Word and multi need word alignment, halfword needs halfword.
// - Unaligned accesses are not performed and raise hard fault.
// - Program counter operand equals instruction address plus four.
// - Carry set from carry-out; flags not updated keep their values.
module shift_carry_unit (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Shift request
  input  wire logic        i_shift_valid,
  input  wire logic [1:0]  i_shift_op,
  input  wire logic        i_flagset,
  input  wire logic [31:0] i_source_operand,
  input  wire logic [31:0] i_length_reg,
  // Operand-shift form of flag-setting move, invert and logic instructions
  input  wire logic        i_operand_shift,
  // Branch and link-register writes
  input  wire logic        i_pc_write,
  input  wire logic [31:0] i_pc_target,
  input  wire logic        i_link_write,
  input  wire logic [31:0] i_return_addr,
  // Memory access check
  input  wire logic        i_mem_valid,
  input  wire logic [1:0]  i_mem_size,
  input  wire logic [31:0] i_mem_addr,
  // Current instruction address
  input  wire logic [31:0] i_instr_addr,
  // Shifter results
  output logic [31:0]      o_shift_result,
  output logic             o_carry_flag,
  output logic             o_shift_done,
  // Branch results
  output logic [31:0]      o_program_counter,
  output logic             o_pc_update,
  output logic             o_isa_fault,
  output logic [31:0]      o_link_register,
  output logic             o_link_update,
  // Memory results
  output logic             o_mem_go,
  output logic             o_hard_fault_exception,
  // Operand value of the program counter
  output logic [31:0]      o_pc_operand
);

  typedef struct packed {
    logic [31:0] shift_result;
    logic        carry_flag;
    logic        shift_done;
    logic [31:0] program_counter;
    logic        pc_update;
    logic        isa_fault;
    logic [31:0] link_register;
    logic        link_update;
    logic        mem_go;
    logic        hard_fault_exception;
    logic [31:0] pc_operand;
  } state_type;

  state_type state;
  state_type next_state;

  logic [31:0] core_result;
  logic        core_carry;
  logic        aligned;
  logic [7:0]  amount;

  assign amount = i_length_reg[7:0];

  barrel_core u_barrel_core (
    .i_op       (shift_unit_pkg::shift_op_type'(i_shift_op)),
    .i_value    (i_source_operand),
    .i_amount   (amount),
    .i_carry_in (state.carry_flag),
    .o_result   (core_result),
    .o_carry    (core_carry)
  );

  always_comb begin
    case (shift_unit_pkg::access_size_type'(i_mem_size))
      shift_unit_pkg::SIZE_BYTE:  aligned = 1'b1;
      shift_unit_pkg::SIZE_HALF:  aligned = ~i_mem_addr[0];
      shift_unit_pkg::SIZE_WORD:  aligned = (i_mem_addr[1:0] == 2'h0);
      shift_unit_pkg::SIZE_MULTI: aligned = (i_mem_addr[1:0] == 2'h0);
      default:                    aligned = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.shift_done = 1'b0;
    next_state.pc_update = 1'b0;
    next_state.link_update = 1'b0;
    next_state.mem_go = 1'b0;
    next_state.hard_fault_exception = 1'b0;
    next_state.isa_fault = 1'b0;
    next_state.pc_operand = i_instr_addr
                            + shift_unit_pkg::PC_READ_OFFSET;
    if (i_shift_valid) begin
      next_state.shift_result = core_result;
      next_state.shift_done = 1'b1;
      // Carry is untouched at zero length since the core echoes it back
      if ((i_flagset || i_operand_shift) && amount != 8'h00) begin
        next_state.carry_flag = core_carry;
      end
    end
    if (i_pc_write) begin
      next_state.program_counter = {i_pc_target[31:1], 1'b0};
      next_state.pc_update = 1'b1;
      next_state.isa_fault = ~i_pc_target[0];
    end
    if (i_link_write) begin
      next_state.link_register = {i_return_addr[31:1], 1'b1};
      next_state.link_update = 1'b1;
    end
    if (i_mem_valid) begin
      next_state.mem_go = aligned;
      next_state.hard_fault_exception = ~aligned;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= '0;
      state.carry_flag <= shift_unit_pkg::CARRY_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign o_shift_result         = state.shift_result;
  assign o_carry_flag           = state.carry_flag;
  assign o_shift_done           = state.shift_done;
  assign o_program_counter      = state.program_counter;
  assign o_pc_update            = state.pc_update;
  assign o_isa_fault            = state.isa_fault;
  assign o_link_register        = state.link_register;
  assign o_link_update          = state.link_update;
  assign o_mem_go               = state.mem_go;
  assign o_hard_fault_exception = state.hard_fault_exception;
  assign o_pc_operand           = state.pc_operand;

endmodule : shift_carry_unit

/* File: rtl/shift_unit_pkg.sv */
package shift_unit_pkg;

  localparam int unsigned DATA_WIDTH   = 32;
  localparam int unsigned AMOUNT_WIDTH = 8;

  // Offset of the program counter as an operand, in bytes
  localparam logic [31:0] PC_READ_OFFSET = 32'h0000_0004;

  // Large-length thresholds
  localparam logic [7:0] SHIFT_FULL  = 8'h20;
  localparam logic [7:0] SHIFT_BEYOND = 8'h21;

  // Reset values
  localparam logic CARRY_RESET = 1'b0;

  typedef enum logic [1:0] {
    OP_LEFT_LOGIC   = 2'h0,
    OP_RIGHT_LOGIC  = 2'h1,
    OP_RIGHT_ARITH  = 2'h3,
    OP_ROTATE_RIGHT = 2'h2
  } shift_op_type;

  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_HALF  = 2'h1,
    SIZE_WORD  = 2'h2,
    SIZE_MULTI = 2'h3
  } access_size_type;

endpackage : shift_unit_pkg

/* File: rtl/barrel_core.sv */
`timescale 1ns/1ns
// Combinational shift and rotate with carry-out; amount is the full byte
module barrel_core (
  // Operation
  input  wire shift_unit_pkg::shift_op_type i_op,
  input  wire logic [31:0]                  i_value,
  input  wire logic [7:0]                   i_amount,
  input  wire logic                         i_carry_in,
  // Result
  output logic [31:0]                       o_result,
  output logic                              o_carry
);

  logic [4:0]  low5;
  logic [63:0] wide;
  logic        is_zero;
  logic        is_full;
  logic        is_big;

  always_comb begin
    low5    = i_amount[4:0];
    is_zero = (i_amount == 8'h00);
    is_full = (i_amount == shift_unit_pkg::SHIFT_FULL);
    is_big  = (i_amount >= shift_unit_pkg::SHIFT_FULL);
    wide    = 64'h0;
    o_result = i_value;
    o_carry  = i_carry_in;
    if (is_zero) begin
      o_result = i_value;
      o_carry  = i_carry_in;
    end else begin
      case (i_op)
        shift_unit_pkg::OP_LEFT_LOGIC: begin
          if (is_big) begin
            o_result = 32'h0;
            o_carry  = is_full ? i_value[0] : 1'b0;
          end else begin
            wide     = {32'h0, i_value} << low5;
            o_result = wide[31:0];
            o_carry  = wide[32];
          end
        end
        shift_unit_pkg::OP_RIGHT_LOGIC: begin
          if (is_big) begin
            o_result = 32'h0;
            o_carry  = is_full ? i_value[31] : 1'b0;
          end else begin
            wide     = {i_value, 32'h0} >> low5;
            o_result = wide[63:32];
            o_carry  = wide[31];
          end
        end
        shift_unit_pkg::OP_RIGHT_ARITH: begin
          if (is_big) begin
            o_result = {32{i_value[31]}};
            o_carry  = i_value[31];
          end else begin
            wide     = $signed({i_value, 32'h0}) >>> low5;
            o_result = wide[63:32];
            o_carry  = wide[31];
          end
        end
        shift_unit_pkg::OP_ROTATE_RIGHT: begin
          // Lengths above 32 fold onto the low five bits
          if (low5 == 5'h00) begin
            o_result = i_value;
            o_carry  = i_value[31];
          end else begin
            wide     = {i_value, i_value} >> low5;
            o_result = wide[31:0];
            o_carry  = wide[31];
          end
        end
        default: begin
          o_result = i_value;
          o_carry  = i_carry_in;
        end
      endcase
    end
  end

endmodule : barrel_core

/* File: test/shift_carry_unit_monitor.sv */
`timescale 1ns/1ns
module shift_carry_unit_monitor (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_shift_valid,
  input wire logic [1:0]  i_shift_op,
  input wire logic        i_flagset,
  input wire logic [31:0] i_source_operand,
  input wire logic [31:0] i_length_reg,
  input wire logic        i_operand_shift,
  input wire logic        i_pc_write,
  input wire logic [31:0] i_pc_target,
  input wire logic        i_link_write,
  input wire logic [31:0] i_return_addr,
  input wire logic        i_mem_valid,
  input wire logic [1:0]  i_mem_size,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_instr_addr,
  input wire logic [31:0] o_shift_result,
  input wire logic        o_carry_flag,
  input wire logic        o_shift_done,
  input wire logic [31:0] o_program_counter,
  input wire logic        o_pc_update,
  input wire logic        o_isa_fault,
  input wire logic [31:0] o_link_register,
  input wire logic        o_link_update,
  input wire logic        o_mem_go,
  input wire logic        o_hard_fault_exception,
  input wire logic [31:0] o_pc_operand
);
  wire logic upd = i_shift_valid && (i_flagset || i_operand_shift);
  wire logic zl  = i_length_reg[7:0] == 8'h00;
  wire logic mis = (i_mem_size[1] && i_mem_addr[1:0] != 2'h0)
                   || (i_mem_size == 2'h1 && i_mem_addr[0]);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_done; i_shift_valid |=> o_shift_done; endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_zero; i_shift_valid && zl |=> $stable(o_carry_flag)
    && o_shift_result == $past(i_source_operand); endproperty
  a_zero: assert property (p_zero) else $error("zero length");
  property p_keep; !upd |=> $stable(o_carry_flag); endproperty
  a_keep: assert property (p_keep) else $error("carry moved");
  property p_arith_big; upd && i_shift_op == 2'h3
    && i_length_reg[7:5] != 3'h0
    |=> o_carry_flag == $past(i_source_operand[31])
    && o_shift_result == {32{$past(i_source_operand[31])}}; endproperty
  a_arith_big: assert property (p_arith_big)
    else $error("arith right large");
  property p_right_big; upd && i_shift_op == 2'h1
    && i_length_reg[7:0] > 8'h20
    |=> !o_carry_flag && o_shift_result == 32'h0; endproperty
  a_right_big: assert property (p_right_big)
    else $error("logic right beyond 32");
  property p_target; i_pc_write |=> o_program_counter
    == ($past(i_pc_target) & 32'hFFFF_FFFE); endproperty
  a_target: assert property (p_target) else $error("target");
  property p_link; i_link_write |=> o_link_update
    && o_link_register == ($past(i_return_addr) | 32'h1); endproperty
  a_link: assert property (p_link) else $error("link bit0");
  property p_isa; i_pc_write |=> o_pc_update
    && o_isa_fault == !$past(i_pc_target[0]); endproperty
  a_isa: assert property (p_isa) else $error("isa bit");
  property p_align; i_mem_valid |=> o_hard_fault_exception == $past(mis)
    && o_mem_go == !$past(mis); endproperty
  a_align: assert property (p_align) else $error("alignment");
  property p_refuse; !i_mem_valid |=> !o_mem_go; endproperty
  a_refuse: assert property (p_refuse) else $error("stray go");
  property p_pcop; !i_rst |=>
    o_pc_operand == $past(i_instr_addr) + 32'h4; endproperty
  a_pcop: assert property (p_pcop) else $error("pc operand");
endmodule : shift_carry_unit_monitor
bind shift_carry_unit shift_carry_unit_monitor mon (.*);

/* File: test/shift_carry_unit_tb.sv */
`timescale 1ns/1ns
module shift_carry_unit_tb;
  logic        i_core_clk, i_rst, i_shift_valid, i_flagset, i_operand_shift;
  logic        i_pc_write, i_link_write, i_mem_valid;
  logic [1:0]  i_shift_op, i_mem_size;
  logic [31:0] i_source_operand, i_length_reg, i_pc_target, i_return_addr;
  logic [31:0] i_mem_addr, i_instr_addr, o_shift_result, o_program_counter;
  logic [31:0] o_link_register, o_pc_operand;
  logic        o_carry_flag, o_shift_done, o_pc_update, o_isa_fault;
  logic        o_link_update, o_mem_go, o_hard_fault_exception;
  int          failures, compares, cycles;
  shift_carry_unit uut (.*);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic sh(logic [1:0] op, logic f, logic o, logic [31:0] v,
                    logic [31:0] l, logic [31:0] er, logic ec);
    @(posedge i_core_clk);
    i_shift_valid    <= 1'b1;
    i_shift_op       <= op;
    i_flagset        <= f;
    i_operand_shift  <= o;
    i_source_operand <= v;
    i_length_reg     <= l;
    @(posedge i_core_clk);
    i_shift_valid <= 1'b0;
    #1 chk("result", er, o_shift_result);
    chk("carry", {31'h0, ec}, {31'h0, o_carry_flag});
    chk("done", 32'h1, {31'h0, o_shift_done});
  endtask : sh
  task automatic br(logic [31:0] t, logic [31:0] r);
    @(posedge i_core_clk);
    i_pc_write    <= 1'b1;
    i_link_write  <= 1'b1;
    i_pc_target   <= t;
    i_return_addr <= r;
    i_instr_addr  <= r;
    @(posedge i_core_clk);
    i_pc_write   <= 1'b0;
    i_link_write <= 1'b0;
    #1 chk("isa", {31'h0, !t[0]}, {31'h0, o_isa_fault});
    chk("target", t & 32'hFFFFFFFE, o_program_counter);
    chk("link", r | 32'h1, o_link_register);
    chk("pc_operand", r + 32'h4, o_pc_operand);
  endtask : br
  task automatic mem(logic [1:0] s, logic [31:0] a, logic bad);
    @(posedge i_core_clk);
    i_mem_valid <= 1'b1;
    i_mem_size  <= s;
    i_mem_addr  <= a;
    @(posedge i_core_clk);
    i_mem_valid <= 1'b0;
    #1 chk("fault", {31'h0, bad}, {31'h0, o_hard_fault_exception});
    chk("go", {31'h0, !bad}, {31'h0, o_mem_go});
  endtask : mem
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      results();
    end
  end
  initial begin
    {i_shift_valid, i_flagset, i_operand_shift, i_pc_write} = 4'h0;
    {i_link_write, i_mem_valid, i_shift_op, i_mem_size} = 6'h00;
    {i_source_operand, i_length_reg, i_pc_target} = 96'h0;
    {i_return_addr, i_mem_addr, i_instr_addr} = 96'h0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    sh(2'h1, 1, 0, 32'h3, 32'h1, 32'h1, 1);
    sh(2'h3, 1, 0, 32'h80000010, 32'h4, 32'hF8000001, 0);
    sh(2'h3, 1, 0, 32'h80000000, 32'h28, 32'hFFFFFFFF, 1);
    sh(2'h0, 1, 0, 32'h80000001, 32'h1, 32'h2, 1);
    sh(2'h1, 1, 0, 32'h1, 32'h21, 32'h0, 0);
    sh(2'h0, 1, 0, 32'h1, 32'h20, 32'h0, 1);
    sh(2'h1, 1, 0, 32'h7FFFFFFF, 32'h20, 32'h0, 0);
    sh(2'h2, 1, 0, 32'h2, 32'h1, 32'h1, 0);
    sh(2'h2, 1, 0, 32'h80000000, 32'h20, 32'h80000000, 1);
    sh(2'h1, 1, 0, 32'h6, 32'h0, 32'h6, 1);
    sh(2'h2, 1, 0, 32'h2, 32'h21, 32'h1, 0);
    sh(2'h0, 0, 0, 32'h80000000, 32'h1, 32'h0, 0);
    sh(2'h0, 0, 1, 32'h80000000, 32'h1, 32'h0, 1);
    sh(2'h1, 1, 0, 32'h5, 32'h100, 32'h5, 1);
    br(32'h00000101, 32'h00001000);
    br(32'h00000200, 32'h00002002);
    mem(2'h0, 32'h3, 0);
    mem(2'h1, 32'h1, 1);
    mem(2'h1, 32'h2, 0);
    mem(2'h2, 32'h2, 1);
    mem(2'h3, 32'h4, 0);
    results();
  end
endmodule : shift_carry_unit_tb
